// *** rtl/pin_mux_map.svh ***
// pin_mux_map.svh: register offsets, field positions, reset values and codes
// assumes: included by bare name from the top module and the bench top
`ifndef PIN_MUX_MAP_SVH
`define PIN_MUX_MAP_SVH

// pads: ports 1 to 6, eight bits each
`define PAD_COUNT 48
// register byte offsets, one aligned word each
`define REG_DIR_LO 6'h00
`define REG_DIR_HI 6'h04
`define REG_SEL_LO 6'h08
`define REG_SEL_HI 6'h0c
`define REG_OUT_LO 6'h10
`define REG_OUT_HI 6'h14
`define REG_ANA 6'h18
`define REG_OPAMP 6'h1c
`define REG_DACLCD 6'h20
`define REG_IN_LO 6'h24
`define REG_IN_HI 6'h28
// writable bits per control word
`define ANA_MASK 32'h0000_0f1f
`define OPAMP_MASK 32'h7773_f777
`define DACLCD_MASK 32'h0000_003f
// analog control word fields
`define ANA_CMP_DIS_LSB 0
`define ANA_T2_HIZ 2
`define ANA_LCD_HI 3
`define ANA_LCD_LO 4
`define ANA_CHAN_LSB 8
// op-amp control word fields
`define OA_INSEL0_LSB 0
`define OA_INSEL1_LSB 4
`define OA_ROUTE_LSB 8
`define OA_PM_LSB 12
`define OA_FC_LSB 20
`define OA_FC_STRIDE 4
// dac and lcd reference word fields
`define DAC_OPS 0
`define DAC_AMP_LSB 1
`define LCD_REF_LSB 4
// status word: fuse flag position in the upper input word
`define IN_HI_FUSE 16
// codes
`define DAC_AMP_HIZ 3'h0
`define DAC_AMP_GND 3'h1
`define LCD_REF_EXT 2'h1
`define ADC_CH_P50 4'hd
`define ADC_CH_P51 4'hc
`define OA_FC_ADC 3'h0
// reset values: all pads general inputs, input buffers on
`define CFG_RST 48'h0000_0000_0000
`define SCHMITT_RST 48'hffff_ffff_ffff
`endif

// *** rtl/pin_mux_pkg.sv ***
// pin_mux_pkg: types shared by the pin multiplexer and its bench
// assumes: map header sits beside it in rtl/
package pin_mux_pkg;
  // avalon-mm request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [5:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avs_req_s;

  // whole state of the multiplexer
  typedef struct packed {
    logic [47:0] dir_r;
    logic [47:0] sel_r;
    logic [47:0] outv_r;
    logic [31:0] ana_r;
    logic [31:0] oa_r;
    logic [31:0] dac_r;
    logic ack_r;
    logic [31:0] rdata_r;
    logic [47:0] sync1_r;
    logic [47:0] sync2_r;
    logic fuse1_r;
    logic fuse2_r;
    logic fuse_lat_r;
    logic [47:0] pad_oe_r;
    logic [47:0] pad_out_r;
    logic [47:0] schmitt_r;
    logic [47:0] analog_r;
    logic [47:0] lcd_r;
    logic [47:0] pin_r;
    logic ext_ref_r;
    logic [2:0] oa_link_r;
  } mux_state_s;
endpackage : pin_mux_pkg

// *** rtl/port_pin_function_mux.sv ***
// port_pin_function_mux: pad function multiplexer for ports 1 to 6
// assumes: one 25 MHz clock, avalon-mm master, pads resolved by the bench
//
// Contract
// - blown fuse: test access off, bypass forever
// - port1 bits0-5: select picks peripheral, direction chooses way
// - comparator disable makes port1 bits6-7 analog
// - port2 bit7 adc clock/dma trigger, bit6 comparator
// - second timer high-z forces its outputs off
// - port3 bits4-7: timer capture in or output
// - port2 uart: bit4 output, bit5 input
// - port3 bits0-3: serial module sets direction
// - two-wire mode pads only pull low
// - port4 bit0 output, bit1 input with select
// - port4 bits2-5: second serial sets direction
// - lcd high group enable makes segment outputs
// - port4 bit6 output, bit7 input with select
// - port5 bit0 segment on select0, op-amp input
// - port5 bit0 adc channel 13 on select
// - select on analog pad kills driver, trigger
// - port5 bit1 dac: hiz, ground or output
// - port5 bits2-4 select gives lcd common
// - port5 bit6 external ref when selection 01
// - port6 even bits: op-amp input or adc
// - port6 bits1, 3 and 5: op-amp output when powered
// - op-amp linked to pad and adc input
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
`include "pin_mux_map.svh"
`timescale 1ns/1ps
`default_nettype none

module port_pin_function_mux
  import pin_mux_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // register bus
  input wire avs_req_s i_avs,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // pads
  input wire logic [47:0] i_pad_in,
  output logic [47:0] o_pad_out,
  output logic [47:0] o_pad_oe,
  output logic [47:0] o_schmitt_en,
  output logic [47:0] o_analog_en,
  output logic [47:0] o_lcd_en,
  // peripherals
  input wire logic [47:0] i_periph_out,
  input wire logic [47:0] i_periph_oe,
  input wire logic i_two_wire_mode,
  output logic [47:0] o_periph_in,
  output logic o_lcd_ext_ref_en,
  output logic [2:0] o_opamp_adc_link,
  // security fuse and test port
  input wire logic i_fuse_blown,
  output logic o_tap_bypass,
  output logic o_test_access_en
);

  ////////////////////////////////////////////////////////////////////////////
  // state and temporaries
  mux_state_s s; // registered state
  mux_state_s n; // next state
  logic bus_req; // read or write pending
  logic d; // direction bit of pad
  logic f; // select bit of pad
  logic oe; // pad driver enable
  logic ov; // pad output value
  logic sch; // input buffer enable
  logic an; // analog connection
  logic lc; // lcd segment or common drive
  logic rt; // pad routed to peripheral input
  logic [31:0] rd; // read mux
  logic [31:0] bm; // byte enables widened to a bit mask
  logic [31:0] wm; // write word merged into the addressed register
  logic [2:0] oa_pad; // op-amp output on its pad
  int k; // op-amp index

  assign bus_req = i_avs.read | i_avs.write;
  // disabled byte lanes keep the old register contents
  assign bm = {{8{i_avs.byteenable[3]}}, {8{i_avs.byteenable[2]}},
      {8{i_avs.byteenable[1]}}, {8{i_avs.byteenable[0]}}};

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    n = s;
    rd = 32'h0000_0000;
    k = 0;
    // one wait cycle, then the request is taken
    n.ack_r = bus_req & ~s.ack_r;
    // pad and fuse synchronisers
    n.sync1_r = i_pad_in;
    n.sync2_r = s.sync1_r;
    n.fuse1_r = i_fuse_blown;
    n.fuse2_r = s.fuse1_r;
    n.fuse_lat_r = s.fuse_lat_r | s.fuse2_r;
    // read data, latched before the answer cycle
    case (i_avs.address)
      `REG_DIR_LO: rd = s.dir_r[31:0];
      `REG_DIR_HI: rd = {16'h0000, s.dir_r[47:32]};
      `REG_SEL_LO: rd = s.sel_r[31:0];
      `REG_SEL_HI: rd = {16'h0000, s.sel_r[47:32]};
      `REG_OUT_LO: rd = s.outv_r[31:0];
      `REG_OUT_HI: rd = {16'h0000, s.outv_r[47:32]};
      `REG_ANA: rd = s.ana_r;
      `REG_OPAMP: rd = s.oa_r;
      `REG_DACLCD: rd = s.dac_r;
      `REG_IN_LO: rd = s.sync2_r[31:0];
      `REG_IN_HI: begin
        rd = {16'h0000, s.sync2_r[47:32]};
        rd[`IN_HI_FUSE] = s.fuse_lat_r;
      end
      default: rd = 32'h0000_0000; // unmapped reads zero
    endcase
    if (i_avs.read & ~s.ack_r) begin
      n.rdata_r = rd;
    end
    // writes take effect on the accepting edge, merged over the read word
    wm = (rd & ~bm) | (i_avs.writedata & bm);
    if (i_avs.write & s.ack_r) begin
      case (i_avs.address)
        `REG_DIR_LO: n.dir_r[31:0] = wm;
        `REG_DIR_HI: n.dir_r[47:32] = wm[15:0];
        `REG_SEL_LO: n.sel_r[31:0] = wm;
        `REG_SEL_HI: n.sel_r[47:32] = wm[15:0];
        `REG_OUT_LO: n.outv_r[31:0] = wm;
        `REG_OUT_HI: n.outv_r[47:32] = wm[15:0];
        `REG_ANA: n.ana_r = wm & `ANA_MASK;
        `REG_OPAMP: n.oa_r = wm & `OPAMP_MASK;
        `REG_DACLCD: n.dac_r = wm & `DACLCD_MASK;
        default: n.dac_r = s.dac_r; // read-only or unmapped: ignored
      endcase
    end
    // op-amp links to pad and converter
    for (int j = 0; j < 3; j++) begin
      n.oa_link_r[j] = s.oa_r[`OA_ROUTE_LSB + j] |
          (s.oa_r[`OA_FC_LSB + `OA_FC_STRIDE*j +: 3] == `OA_FC_ADC);
      oa_pad[j] = n.oa_link_r[j] & (s.oa_r[`OA_PM_LSB + 2*j +: 2] != 2'h0);
    end
    // external charge-pump reference on port5 bit6
    n.ext_ref_r = s.sel_r[38] &
        (s.dac_r[`LCD_REF_LSB +: 2] == `LCD_REF_EXT);
    // per-pad decode, lowest priority first
    for (int p = 0; p < `PAD_COUNT; p++) begin
      d = s.dir_r[p];
      f = s.sel_r[p];
      oe = d; // general i/o by direction
      ov = s.outv_r[p];
      sch = 1'b1;
      an = 1'b0;
      lc = 1'b0;
      rt = 1'b0;
      if (p <= 5) begin
        // port1 timer and clock pads
        if (f) begin
          ov = i_periph_out[p];
          rt = ~d;
        end
      end else if (p <= 7) begin
        // comparator inputs
        if (s.ana_r[`ANA_CMP_DIS_LSB + p - 6]) begin
          oe = 1'b0;
          sch = 1'b0;
          an = 1'b1;
        end
      end else if (p <= 11) begin
        // port2 timer pads, bits1-3 on the second timer
        if (f) begin
          ov = i_periph_out[p];
          rt = ~d;
          if (p != 8 && s.ana_r[`ANA_T2_HIZ]) begin
            oe = 1'b0;
          end
        end
      end else if (p == 12 || p == 13) begin
        // uart transmit and receive
        if (f) begin
          oe = (p == 12);
          ov = i_periph_out[p];
          rt = (p == 13);
        end
      end else if (p == 14) begin
        // comparator result out
        if (f & d) begin
          ov = i_periph_out[p];
        end
      end else if (p == 15) begin
        // adc clock out or dma trigger in
        if (f) begin
          ov = i_periph_out[p];
          rt = ~d;
        end
      end else if (p <= 19) begin
        // synchronous serial pads
        if (f) begin
          oe = i_periph_oe[p];
          ov = i_periph_out[p];
          rt = 1'b1;
          if ((p == 17 || p == 18) && i_two_wire_mode) begin
            oe = i_periph_oe[p] & ~i_periph_out[p];
            ov = 1'b0;
          end
        end
      end else if (p <= 23) begin
        // port3 second-timer channels
        if (f) begin
          ov = i_periph_out[p];
          rt = ~d;
          if (s.ana_r[`ANA_T2_HIZ]) begin
            oe = 1'b0;
          end
        end
      end else if (p == 24 || p == 25 || p == 30 || p == 31) begin
        // fixed-direction serial pads
        if (f) begin
          oe = (p == 24 || p == 30);
          ov = i_periph_out[p];
          rt = (p == 25 || p == 31);
        end
      end else if (p <= 29) begin
        // second serial module, direction from the module
        if (f) begin
          oe = i_periph_oe[p];
          ov = i_periph_out[p];
          rt = 1'b1;
        end
      end else if (p == 32) begin
        // port5 bit0: op-amp input or adc channel
        if (~d && s.oa_r[`OA_INSEL1_LSB +: 3] == 3'h1) begin
          an = 1'b1;
        end
        if (f) begin
          oe = 1'b0;
          sch = 1'b0;
          an = (s.ana_r[`ANA_CHAN_LSB +: 4] == `ADC_CH_P50);
        end
      end else if (p == 33) begin
        // port5 bit1: adc channel 12
        if (f) begin
          oe = 1'b0;
          sch = 1'b0;
          an = (s.ana_r[`ANA_CHAN_LSB +: 4] == `ADC_CH_P51);
        end
      end else if (p <= 36) begin
        // lcd common outputs
        if (f) begin
          oe = 1'b0;
          sch = 1'b0;
          lc = 1'b1;
        end
      end else if (p <= 39) begin
        // lcd bias levels and reference
        if (f) begin
          oe = 1'b0;
          sch = 1'b0;
          an = 1'b1;
        end
      end else begin
        // port6 analog pads
        k = (p - 41) / 2;
        if (f) begin
          oe = 1'b0;
          sch = 1'b0;
          an = (s.ana_r[`ANA_CHAN_LSB +: 4] == 4'(p - 40));
        end
        if (~d && ((p == 40 && s.oa_r[`OA_INSEL0_LSB +: 3] == 3'h0) ||
            (p == 42 && s.oa_r[`OA_INSEL0_LSB +: 3] == 3'h1) ||
            (p == 44 && s.oa_r[`OA_INSEL1_LSB +: 3] == 3'h0))) begin
          an = 1'b1;
        end
        if ((p == 41 || p == 43 || p == 45) && oa_pad[k]) begin
          oe = 1'b0;
          sch = 1'b0;
          an = 1'b1;
        end
      end
      // lcd segment enables win over the per-port decode above; the low group only where select is clear
      if (s.ana_r[`ANA_LCD_HI] && p >= 26 && p <= 31) begin
        oe = 1'b0;
        sch = 1'b0;
        an = 1'b0;
        rt = 1'b0;
        lc = 1'b1;
      end
      if (s.ana_r[`ANA_LCD_LO] && (p == 32 || p == 33)) begin
        oe = 1'b0;
        lc = ~f;
        if (~f) begin
          sch = 1'b0;
          an = 1'b0;
        end
      end
      // dac output selector on port5 bit1 overrides the rest
      if (p == 33 && s.dac_r[`DAC_OPS]) begin
        sch = 1'b0;
        lc = 1'b0;
        an = 1'b0;
        ov = 1'b0;
        oe = 1'b0;
        if (s.dac_r[`DAC_AMP_LSB +: 3] == `DAC_AMP_GND) begin
          oe = 1'b1;
        end else if (s.dac_r[`DAC_AMP_LSB +: 3] != `DAC_AMP_HIZ) begin
          an = 1'b1;
        end
      end
      n.pad_oe_r[p] = oe;
      n.pad_out_r[p] = ov;
      n.schmitt_r[p] = sch;
      n.analog_r[p] = an;
      n.lcd_r[p] = lc;
      n.pin_r[p] = rt & sch & s.sync2_r[p];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s <= '0;
      s.schmitt_r <= `SCHMITT_RST;
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign o_avs_waitrequest = bus_req & ~s.ack_r;
  assign o_avs_readdata = s.rdata_r;
  assign o_pad_out = s.pad_out_r;
  assign o_pad_oe = s.pad_oe_r;
  assign o_schmitt_en = s.schmitt_r;
  assign o_analog_en = s.analog_r;
  assign o_lcd_en = s.lcd_r;
  assign o_periph_in = s.pin_r;
  assign o_lcd_ext_ref_en = s.ext_ref_r;
  assign o_opamp_adc_link = s.oa_link_r;
  assign o_tap_bypass = s.fuse_lat_r;
  assign o_test_access_en = ~s.fuse_lat_r;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_fuse_seen;
    i_fuse_blown ##1 i_fuse_blown ##1 i_fuse_blown;
  endsequence
  property p_fuse_bypass;
    s_fuse_seen |=> o_tap_bypass && !o_test_access_en ##1 o_tap_bypass;
  endproperty
  a_fuse_bypass: assert property (p_fuse_bypass) else $error("fuse bypass missing");
  property p_p1_out;
    (s.sel_r[0] && s.dir_r[0]) |=> o_pad_oe[0] && o_pad_out[0] == $past(i_periph_out[0]);
  endproperty
  a_p1_out: assert property (p_p1_out) else $error("port1 bit0 not driven by timer");
  property p_cmp_analog;
    s.ana_r[`ANA_CMP_DIS_LSB] |=> !o_pad_oe[6] && o_analog_en[6] && !o_schmitt_en[6];
  endproperty
  a_cmp_analog: assert property (p_cmp_analog) else $error("comparator pad not analog");
  property p_t2_hiz;
    (s.ana_r[`ANA_T2_HIZ] && s.sel_r[21] && s.dir_r[21]) |=> !o_pad_oe[21];
  endproperty
  a_t2_hiz: assert property (p_t2_hiz) else $error("timer output not high impedance");
  property p_uart_dir;
    (s.sel_r[12] && s.sel_r[13] && !s.ana_r[`ANA_LCD_HI]) |=> o_pad_oe[12] && !o_pad_oe[13];
  endproperty
  a_uart_dir: assert property (p_uart_dir) else $error("uart pad direction wrong");
  property p_two_wire;
    (i_two_wire_mode && s.sel_r[17]) |=> !(o_pad_oe[17] && o_pad_out[17]);
  endproperty
  a_two_wire: assert property (p_two_wire) else $error("two-wire pad driven high");
  property p_lcd_hi;
    s.ana_r[`ANA_LCD_HI] |=> o_lcd_en[26] && !o_pad_oe[26] && o_lcd_en[31];
  endproperty
  a_lcd_hi: assert property (p_lcd_hi) else $error("lcd segment override lost");
  property p_dac_gnd;
    (s.dac_r[`DAC_OPS] && s.dac_r[`DAC_AMP_LSB +: 3] == `DAC_AMP_GND)
        |=> o_pad_oe[33] && !o_pad_out[33] && !o_analog_en[33];
  endproperty
  a_dac_gnd: assert property (p_dac_gnd) else $error("dac pad not grounded");
  sequence s_bus_wait;
    bus_req && o_avs_waitrequest;
  endsequence
  property p_bus_answer;
    s_bus_wait |=> !o_avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

endmodule : port_pin_function_mux

`default_nettype wire

// *** verification/pad_board_model.sv ***
// pad_board_model: board side of the pads, the level each pad settles to
// assumes: enables and values come straight from the pad multiplexer
`timescale 1ns/1ps
`default_nettype none

module pad_board_model (
  // from the multiplexer
  input wire logic [47:0] i_oe,
  input wire logic [47:0] i_out,
  // board levels and two-wire pull-ups set by the bench
  input wire logic [47:0] i_board,
  input wire logic i_pullup,
  // resolved pad levels
  output logic [47:0] o_pad
);
  // driver wins, else pull-up on the two-wire pads, else board level
  always_comb begin
    for (int i = 0; i < 48; i++) begin
      if (i_oe[i]) begin
        o_pad[i] = i_out[i];
      end else if (i_pullup && (i == 17 || i == 18)) begin
        o_pad[i] = 1'b1;
      end else begin
        o_pad[i] = i_board[i];
      end
    end
  end
endmodule : pad_board_model
`default_nettype wire

// *** verification/port_pin_function_mux_tb_top.sv ***
// port_pin_function_mux_tb_top: self-checking bench for the pad multiplexer
// assumes: package, map header and pad_board_model compiled first
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_map.svh"

module port_pin_function_mux_tb_top
  import pin_mux_pkg::*;
;
  // dut wiring
  logic clk, rst, wait_req, twm, ext_ref, fuse, bypass, test_en;
  avs_req_s avs;
  logic [31:0] rdata, d, q;
  logic [47:0] pad_in, pad_out, pad_oe, schmitt, analog, lcd, pout, poe, per_in, board;
  logic [2:0] oa_link, e;
  // reference model state
  logic [47:0] dir_m, sel_m, out_m, eo, ev, ri;
  logic hiz_m, lcd_m;
  logic [31:0] seed = 32'h0000_5ddb;
  int mismatches, compares, cycles;
  localparam logic [47:0] MSK = 48'h0000_ffff_ffff;

  port_pin_function_mux uut (
    .i_clk(clk), .i_rst(rst), .i_avs(avs), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_req), .i_pad_in(pad_in), .o_pad_out(pad_out),
    .o_pad_oe(pad_oe), .o_schmitt_en(schmitt), .o_analog_en(analog), .o_lcd_en(lcd),
    .i_periph_out(pout), .i_periph_oe(poe), .i_two_wire_mode(twm), .o_periph_in(per_in),
    .o_lcd_ext_ref_en(ext_ref), .o_opamp_adc_link(oa_link), .i_fuse_blown(fuse),
    .o_tap_bypass(bypass), .o_test_access_en(test_en)
  );
  pad_board_model board_u (
    .i_oe(pad_oe), .i_out(pad_out), .i_board(board), .i_pullup(twm), .o_pad(pad_in)
  );

  ////////////////////////////////////////////////////////////////
  // xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // reference pad model, ports 1 to 4: {drive, value, routed in}
  function automatic logic [2:0] model_pad(input int p);
    logic s, dr, po;
    s = sel_m[p];
    dr = dir_m[p];
    po = pout[p];
    if (p == 6 || p == 7) return {dr, out_m[p], 1'b0};
    if (p >= 26 && lcd_m) return 3'b000;
    if (!s) return {dr, out_m[p], 1'b0};
    if (p == 14) return {dr, po, 1'b0};
    if (p == 12 || p == 24 || p == 30) return {1'b1, po, 1'b0};
    if (p == 13 || p == 25 || p == 31) return 3'b001;
    if (p inside {[16:19], [26:29]}) return {poe[p], po, 1'b0};
    if (hiz_m && (p inside {[9:11], [20:23]})) return {2'b00, !dr};
    return {dr, po, !dr};
  endfunction : model_pad

  // avalon transfer: hold until waitrequest low, then release; only the hang guard ends a wait
  task automatic bus(input logic rd, input logic [5:0] a, input logic [31:0] wd);
    @(posedge clk);
    avs <= '{rd, !rd, a, wd, 4'hf};
    do begin
      @(posedge clk);
    end while (wait_req !== 1'b0);
    q = rdata;
    avs <= '0;
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] wd);
    bus(1'b0, a, wd);
  endtask : wr

  // let pads, syncs and flags land, sample mid-cycle
  task automatic settle();
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask : settle

  // compare tasks: pad vectors and bus words
  task automatic chk_pad(input logic [47:0] got, input logic [47:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_pad

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    chk_pad({16'h0, got}, {16'h0, exp});
  endtask : chk_word

  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      mismatches++;
      complete_run();
    end
  end

  // main sequence
  initial begin
    rst = 1'b1;
    avs = '0;
    twm = 1'b0;
    fuse = 1'b0;
    pout = '0;
    poe = '0;
    board = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk_pad(pad_oe | analog | lcd, '0);
    chk_pad(schmitt, {48{1'b1}});
    chk_pad({46'h0, bypass, test_en}, 48'h1);
    // register access, masks and an unmapped place
    wr(`REG_ANA, 32'hffff_ffff);
    bus(1'b1, `REG_ANA, '0);
    chk_word(q, `ANA_MASK);
    bus(1'b1, 6'h3c, '0);
    chk_word(q, '0);
    // random sweep over ports 1 to 4
    for (int k = 0; k < 24; k++) begin
      dir_m[31:0] = rnd();
      sel_m[31:0] = rnd();
      out_m[31:0] = rnd();
      d = rnd();
      hiz_m = d[0];
      lcd_m = d[1];
      wr(`REG_DIR_LO, dir_m[31:0]);
      wr(`REG_SEL_LO, sel_m[31:0]);
      wr(`REG_OUT_LO, out_m[31:0]);
      wr(`REG_ANA, {28'h0, lcd_m, hiz_m, 2'b00});
      pout <= {16'h0, rnd()};
      poe <= {16'h0, rnd()};
      board <= {d[31:16], rnd()};
      bus(1'b1, `REG_DIR_LO, '0);
      chk_word(q, dir_m[31:0]);
      settle();
      eo = '0;
      ev = '0;
      ri = '0;
      for (int p = 0; p < 32; p++) begin
        e = model_pad(p);
        eo[p] = e[2] & MSK[p];
        ev[p] = e[1] & e[2] & MSK[p];
        ri[p] = e[0] & MSK[p];
      end
      chk_pad(pad_oe & MSK, eo);
      chk_pad(pad_out & eo, ev);
      chk_pad(per_in & ri, board & ri);
      chk_pad(lcd & 48'hfc00_0000, lcd_m ? 48'hfc00_0000 : 48'h0);
    end
    // analog pads: comparator, adc, lcd common, reference, dac
    wr(`REG_SEL_LO, '0);
    wr(`REG_DIR_LO, 32'h40);
    wr(`REG_ANA, 32'h0d01);
    wr(`REG_SEL_HI, 32'h0145);
    wr(`REG_DIR_HI, '0);
    wr(`REG_OPAMP, 32'h1100);
    for (int a = 0; a < 3; a++) begin
      wr(`REG_DACLCD, {26'h0, 2'b01, 3'(a), 1'b1});
      settle();
      e = (a == 0) ? 3'b000 : (a == 1) ? 3'b010 : 3'b100;
      chk_pad({45'h0, analog[33], pad_oe[33], pad_out[33] & pad_oe[33]}, {45'h0, e});
    end
    chk_pad({44'h0, analog[32], schmitt[32], pad_oe[40], schmitt[40]}, 48'h8);
    chk_pad({44'h0, lcd[34], ext_ref, analog[6], pad_oe[6]}, 48'he);
    chk_pad({46'h0, analog[41], oa_link[0]}, 48'h3);
    wr(`REG_OPAMP, 32'h0010_0000);
    wr(`REG_DACLCD, 32'h20);
    wr(`REG_ANA, 32'h10);
    wr(`REG_SEL_HI, 32'h0144);
    settle();
    chk_pad({44'h0, analog[41], oa_link[0], ext_ref, lcd[32]}, 48'h1);
    // two-wire pad only pulls low
    wr(`REG_SEL_LO, 32'h0002_0000);
    for (int v = 0; v < 2; v++) begin
      @(posedge clk);
      twm <= 1'b1;
      poe <= 48'h2_0000;
      pout <= 48'(v) << 17;
      settle();
      chk_pad({46'h0, pad_oe[17], pad_out[17] & pad_oe[17]}, {46'h0, v == 0, 1'b0});
    end
    // fuse blow is sticky
    @(posedge clk);
    fuse <= 1'b1;
    settle();
    chk_pad({46'h0, bypass, test_en}, 48'h2);
    @(posedge clk);
    fuse <= 1'b0;
    settle();
    chk_pad({46'h0, bypass, test_en}, 48'h2);
    complete_run();
  end
endmodule : port_pin_function_mux_tb_top
`default_nettype wire
